// ---- verilog/sci_pkg.sv ----
// constants for the scan chain identification and boundary cells
package sci_pkg;
	localparam int unsigned IDW         = 32;
	localparam int unsigned BSW         = 196;
	localparam int unsigned IRW         = 3;
	localparam int unsigned SYNC_STAGES = 3;
	// instruction codes
	localparam logic [2:0] INS_EXTEST   = 3'h0;
	localparam logic [2:0] INS_IDCODE   = 3'h1;
	localparam logic [2:0] INS_SAMPLE   = 3'h2;
	localparam logic [2:0] INS_CLAMP    = 3'h3;
	localparam logic [2:0] INS_HIGHZ    = 3'h4;
	localparam logic [2:0] INS_BYPASS   = 3'h7;
	// identification fields, values arbitrary
	localparam logic [3:0]  ID_VERSION  = 4'h1;
	localparam logic [15:0] ID_PART     = 16'h5A5A;
	localparam logic [10:0] ID_MAKER    = 11'h0AA;
	localparam logic        ID_LSB      = 1'b1;
	// cell positions in the boundary chain
	localparam int unsigned CELL_GLOBAL_OUTPUT_DISABLE = 0;
	localparam int unsigned CELL_IRQ_PIN_DRIVE         = 2;
	localparam int unsigned CELL_IRQ_PIN_OUTPUT        = 3;
	localparam int unsigned CELL_IRQ_PIN_CAPTURE       = 4;
	localparam int unsigned CELL_TX_FRAME_SYNC_DIR     = 24;
	localparam int unsigned CELL_TX_FRAME_SYNC_OUTPUT  = 25;
	localparam int unsigned CELL_TX_FRAME_SYNC_CAPTURE = 26;
	// reset values of the latched stages
	localparam logic [BSW-1:0] BS_RESET = {BSW{1'b0}};
	localparam logic [IDW-1:0] ID_RESET = {IDW{1'b0}};
	// serial path selection
	typedef enum logic [1:0] {SCI_SEL_BYPASS, SCI_SEL_ID, SCI_SEL_BS}
		sci_sel_t;
endpackage

// ---- verilog/sci_scan_regs.sv ----
// identification, bypass and boundary test data registers
// How it works
// - the identification register is a 32-bit shift stage plus a 32-bit latch.
// - the id register is in the path under its instruction or in reset state.
// - the boundary chain has 196 cells, each a shift stage and a latch.
// - cell 0 latched at 1 floats every output, at 0 lets outputs drive.
// - cells 2 and 3 both at 0 pull the interrupt pin low, 4 captures.
// - cell 24 at 1 makes frame sync an input, cell 25 drives, 26 captures.
// - the id value has lsb one, 11 maker bits, 16 part bits, 4 version bits.
// - the id value loads on the test clock rise after entering capture.
// - on the test clock fall in update the shift stage goes to the latch.
// - the bypass register is one shift bit for bypass, clamp and high-z.
module sci_scan_regs
	import sci_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire logic                 tck,
	input  wire logic                 tdi,
	input  wire logic                 tap_reset,
	input  wire logic                 tap_capture_dr,
	input  wire logic                 tap_shift_dr,
	input  wire logic                 tap_update_dr,
	input  wire logic [sci_pkg::IRW-1:0] instr,
	input  wire logic [sci_pkg::BSW-1:0] pin_sense,
	output logic                      tdo,
	output logic [sci_pkg::BSW-1:0]   bs_latch,
	output logic [sci_pkg::IDW-1:0]   id_latch,
	output logic                      bs_drive_pins,
	output logic                      outputs_hiz,
	output logic                      host_interrupt_pin_oe,
	output logic                      host_interrupt_pin_out,
	output logic                      tx_frame_sync_pin_oe,
	output logic                      tx_frame_sync_pin_out
);
	localparam int unsigned NSYNC = 6 + IRW + BSW;
	localparam logic [IDW-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER,
		ID_LSB};

	// reset release through two flops
	logic [1:0] rst_sync_q;
	logic       rst_ok;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_ok = rst_sync_q[1];

	// three stage sampling of all link inputs
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	assign raw = {tck, tdi, tap_reset, tap_capture_dr, tap_shift_dr,
		tap_update_dr, instr, pin_sense};
	// level filter, a change counts once stages two and three agree
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < NSYNC; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end
	// sampling flops and filtered level
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else if (ce) begin
			s1_q  <= raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// decoded, filtered link view
	logic           tck_l, tdi_l, reset_l, cap_l, shf_l, upd_l;
	logic [IRW-1:0] ins_l;
	logic [BSW-1:0] pins_l;
	logic           tck_prev_q, tck_rise, tck_fall;
	assign tck_l  = lvl_q[NSYNC-1];
	assign tdi_l  = lvl_q[NSYNC-2];
	assign reset_l = lvl_q[NSYNC-3];
	assign cap_l  = lvl_q[NSYNC-4];
	assign shf_l  = lvl_q[NSYNC-5];
	assign upd_l  = lvl_q[NSYNC-6];
	assign ins_l  = lvl_q[BSW +: IRW];
	assign pins_l = lvl_q[BSW-1:0];

	// edges of the filtered test clock
	assign tck_rise = tck_l & ~tck_prev_q;
	assign tck_fall = ~tck_l & tck_prev_q;

	// which register sits in the serial path
	function automatic sci_sel_t path_of(input logic [IRW-1:0] ins,
		input logic rst_state);
		if (rst_state || ins == INS_IDCODE) begin
			return SCI_SEL_ID;
		end
		case (ins)
			INS_EXTEST, INS_SAMPLE: return SCI_SEL_BS;
			default:                return SCI_SEL_BYPASS;
		endcase
	endfunction

	sci_sel_t       sel;
	logic [IDW-1:0] id_sh_q, id_sh_d, id_lt_q, id_lt_d;
	logic [BSW-1:0] bs_sh_q, bs_sh_d, bs_lt_q, bs_lt_d;
	logic           byp_q, byp_d, tdo_q, tdo_d;
	assign sel = path_of(ins_l, reset_l);

	// capture, shift and update of the test data registers
	always_comb begin
		id_sh_d = id_sh_q;
		bs_sh_d = bs_sh_q;
		byp_d   = byp_q;
		id_lt_d = id_lt_q;
		bs_lt_d = bs_lt_q;
		tdo_d   = tdo_q;
		if (tck_rise && cap_l) begin
			case (sel)
				SCI_SEL_ID: id_sh_d = ID_VALUE;
				SCI_SEL_BS: bs_sh_d = pins_l;
				SCI_SEL_BYPASS: byp_d = 1'b0;
				default: byp_d = 1'b0;
			endcase
		end else if (tck_rise && shf_l) begin
			case (sel)
				SCI_SEL_ID: id_sh_d = {tdi_l, id_sh_q[IDW-1:1]};
				SCI_SEL_BS: bs_sh_d = {tdi_l, bs_sh_q[BSW-1:1]};
				SCI_SEL_BYPASS: byp_d = tdi_l;
				default: byp_d = tdi_l;
			endcase
		end
		if (tck_fall && upd_l) begin
			case (sel)
				SCI_SEL_ID: id_lt_d = id_sh_q;
				SCI_SEL_BS: bs_lt_d = bs_sh_q;
				default: id_lt_d = id_lt_q;
			endcase
		end
		// serial output changes on the falling test clock
		if (tck_fall) begin
			case (sel)
				SCI_SEL_ID: tdo_d = id_sh_q[0];
				SCI_SEL_BS: tdo_d = bs_sh_q[0];
				default:    tdo_d = byp_q;
			endcase
		end
	end

	// test data register flops
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok) begin
			tck_prev_q <= 1'b0;
			id_sh_q    <= ID_RESET;
			id_lt_q    <= ID_RESET;
			bs_sh_q    <= BS_RESET;
			bs_lt_q    <= BS_RESET;
			byp_q      <= 1'b0;
			tdo_q      <= 1'b0;
		end else if (ce) begin
			tck_prev_q <= tck_l;
			id_sh_q    <= id_sh_d;
			id_lt_q    <= id_lt_d;
			bs_sh_q    <= bs_sh_d;
			bs_lt_q    <= bs_lt_d;
			byp_q      <= byp_d;
			tdo_q      <= tdo_d;
		end
	end

	// pin control from the latched boundary cells
	logic drv_d, hiz_d, irq_oe_d, fs_oe_d, fs_out_d, irq_out_d;
	logic drv_q, hiz_q, irq_oe_q, fs_oe_q, fs_out_q, irq_out_q;
	always_comb begin
		drv_d = (ins_l == INS_EXTEST || ins_l == INS_CLAMP) && !reset_l;
		hiz_d = (ins_l == INS_HIGHZ && !reset_l)
			|| (drv_d && bs_lt_q[CELL_GLOBAL_OUTPUT_DISABLE]);
		irq_oe_d = drv_d && !hiz_d && !bs_lt_q[CELL_IRQ_PIN_DRIVE]
			&& !bs_lt_q[CELL_IRQ_PIN_OUTPUT];
		fs_oe_d  = drv_d && !hiz_d && !bs_lt_q[CELL_TX_FRAME_SYNC_DIR];
		fs_out_d = bs_lt_q[CELL_TX_FRAME_SYNC_OUTPUT];
		irq_out_d = 1'b0; // open drain, only pulls low
	end
	// pin control flops, outputs leave straight from these
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok) begin
			drv_q    <= 1'b0;
			irq_out_q <= 1'b0;
			hiz_q    <= 1'b0;
			irq_oe_q <= 1'b0;
			fs_oe_q  <= 1'b0;
			fs_out_q <= 1'b0;
		end else if (ce) begin
			drv_q    <= drv_d;
			hiz_q    <= hiz_d;
			irq_oe_q <= irq_oe_d;
			fs_oe_q  <= fs_oe_d;
			fs_out_q <= fs_out_d;
			irq_out_q <= irq_out_d;
		end
	end

	// serial output and latched register views
	assign tdo                    = tdo_q;
	assign bs_latch               = bs_lt_q;
	assign id_latch               = id_lt_q;

	// pin controls
	assign bs_drive_pins          = drv_q;
	assign outputs_hiz            = hiz_q;
	assign host_interrupt_pin_oe  = irq_oe_q;
	assign host_interrupt_pin_out = irq_out_q;
	assign tx_frame_sync_pin_oe   = fs_oe_q;
	assign tx_frame_sync_pin_out  = fs_out_q;
endmodule

// ---- testbench/sci_scan_props.sv ----
// assertions on the scan register outputs
module sci_scan_props
	import sci_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  tap_reset,
	input wire logic                  tap_capture_dr,
	input wire logic                  tap_shift_dr,
	input wire logic [sci_pkg::BSW-1:0] bs_latch,
	input wire logic [sci_pkg::IDW-1:0] id_latch,
	input wire logic                  bs_drive_pins,
	input wire logic                  outputs_hiz,
	input wire logic                  host_interrupt_pin_oe,
	input wire logic                  host_interrupt_pin_out,
	input wire logic                  tx_frame_sync_pin_oe,
	input wire logic                  tx_frame_sync_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// pin controls follow the latched cells one clock later
	chk_irq_open_drain: assert property (!host_interrupt_pin_out)
		else $error("interrupt pin output not low");
	chk_irq_drive_low: assert property (host_interrupt_pin_oe |->
		!$past(bs_latch[2]) && !$past(bs_latch[3]) && bs_drive_pins)
		else $error("interrupt pin pulled without cause");
	chk_hiz_cell_zero: assert property (bs_drive_pins |->
		outputs_hiz == $past(bs_latch[0]))
		else $error("float state does not follow cell 0");
	chk_hiz_all_float: assert property (outputs_hiz |->
		!host_interrupt_pin_oe && !tx_frame_sync_pin_oe)
		else $error("pin driven while floating");
	chk_fs_dir_cell: assert property (tx_frame_sync_pin_oe |->
		!$past(bs_latch[24]) && bs_drive_pins)
		else $error("frame sync driven without cause");
	chk_fs_out_cell: assert property (tx_frame_sync_pin_out ==
		$past(bs_latch[25]))
		else $error("frame sync value not cell 25");
	chk_shift_keeps_latch: assert property (tap_shift_dr [*8] |->
		$stable(bs_latch) && $stable(id_latch))
		else $error("latch moved during shift");
	chk_capture_keeps_latch: assert property
		((tap_capture_dr && !tap_reset) [*8] |-> $stable(bs_latch))
		else $error("latch moved during capture");
endmodule

bind sci_scan_regs sci_scan_props u_sci_scan_props (.*);

// ---- testbench/sci_tester.sv ----
// boundary scan tester model driving the test access lines
module sci_tester (
	input  wire logic clk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tdi,
	output logic      tap_reset,
	output logic      tap_capture_dr,
	output logic      tap_shift_dr,
	output logic      tap_update_dr
);
	timeunit 1ns;
	timeprecision 1ns;
	// lines idle, test clock stands still between states
	initial {tck, tdi, tap_reset, tap_capture_dr, tap_shift_dr,
		tap_update_dr} = '0;
	// one test clock period per state, lines held around both edges
	task automatic step(input logic [3:0] st, input logic d,
		output logic o);
		@(posedge clk);
		{tap_reset, tap_capture_dr, tap_shift_dr, tap_update_dr} <= st;
		tdi <= st[1] ? d : ~tdi; // released data line keeps toggling
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		tck <= 1'b0;
		repeat (6) @(posedge clk);
		o = tdo;
	endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the scan registers
module tb import sci_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic           clk, rst_n, ce, tck, tdi, tdo, o;
	logic           tap_reset, tap_capture_dr, tap_shift_dr, tap_update_dr;
	logic           bs_drive_pins, outputs_hiz, host_interrupt_pin_oe;
	logic           host_interrupt_pin_out, tx_frame_sync_pin_oe;
	logic           tx_frame_sync_pin_out;
	logic [IRW-1:0] instr;
	logic [BSW-1:0] pin_sense, bs_latch, q, r;
	logic [IDW-1:0] id_latch;
	int             n_fail, compares;
	sci_scan_regs u_sci_scan_regs (.*);
	sci_tester    u_sci_tester (.*);
	// system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [BSW-1:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	// capture, n shifts lsb first, update
	task automatic scan(input logic [IRW-1:0] ins, input int n,
		input logic [BSW-1:0] d, output logic [BSW-1:0] got);
		got = '0;
		@(posedge clk);
		instr <= ins;
		u_sci_tester.step(4'h4, 1'b0, got[0]);
		for (int i = 0; i < n; i++) begin
			u_sci_tester.step(4'h2, d[i], o);
			if (i < n - 1) got[i+1] = o;
		end
		u_sci_tester.step(4'h1, 1'b0, o);
		repeat (4) @(posedge clk);
	endtask
	task automatic t_reset_path;
		@(posedge clk);
		instr <= INS_BYPASS;
		u_sci_tester.step(4'hC, 1'b0, o);
		check(o, ID_LSB);
	endtask
	task automatic t_id;
		scan(INS_IDCODE, IDW, 196'h1234ABCD, r);
		check(r[0], 1'b1);
		check(r[11:1], ID_MAKER);
		check(r[27:12], ID_PART);
		check(r[31:28], ID_VERSION);
		check(id_latch, 32'h1234ABCD);
	endtask
	task automatic t_boundary;
		q = {49{4'h6}};
		q[2] = 1'b0;
		pin_sense <= {49{4'h9}};
		scan(INS_SAMPLE, BSW, q, r);
		check(r, {49{4'h9}});
		check(bs_latch, q);
		check(bs_drive_pins, 1'b0);
		for (int k = 0; k < 3; k++) begin
			q[2] = k[0];
			q[24] = k[0];
			q[25] = k[1];
			q[0] = k[1];
			scan(INS_EXTEST, BSW, q, r);
			check(r, {49{4'h9}});
			check(bs_latch, q);
			check(outputs_hiz, k[1]);
			check(host_interrupt_pin_oe, k == 0);
			check(host_interrupt_pin_out, 1'b0);
			check(tx_frame_sync_pin_oe, k == 0);
			check({bs_drive_pins, tx_frame_sync_pin_out}, {1'b1, k[1]});
		end
	endtask
	// clock enable low: a whole scan must leave no trace
	task automatic t_freeze;
		@(posedge clk);
		ce <= 1'b0;
		scan(INS_EXTEST, 8, ~q, r);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		check(bs_latch, q);
		check(outputs_hiz, 1'b1);
	endtask
	task automatic t_bypass;
		logic [IRW-1:0] ins[4] = '{INS_BYPASS, 3'h6, INS_CLAMP, INS_HIGHZ};
		for (int k = 0; k < 4; k++) begin
			scan(ins[k], 2, 196'h1, r);
			check(r, 196'h2);
			check(bs_latch, q);
		end
		check(outputs_hiz, 1'b1);
	endtask
	// reset in mid run, then the id path must work again
	task automatic t_mid_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check(bs_latch, BS_RESET);
		check(id_latch, ID_RESET);
		check(outputs_hiz, 1'b0);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		scan(INS_IDCODE, IDW, 196'hC3A55A3C, r);
		check(r[0], 1'b1);
		check(id_latch, 32'hC3A55A3C);
	endtask
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		{rst_n, ce, instr, pin_sense} = '0;
		n_fail = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		ce <= 1'b1;
		repeat (10) @(posedge clk);
		t_reset_path;
		t_id;
		t_boundary;
		t_freeze;
		t_bypass;
		t_mid_reset;
		stop_test;
	end
	// watchdog
	initial begin
		#400000;
		n_fail++;
		stop_test;
	end
endmodule
